// file: rtl/mfp_map.svh
// register map, preset tables and pin indices for the pin setup block
`ifndef MFP_MAP_SVH
`define MFP_MAP_SVH
`define MFP_OFS_DEV_CFG   8'h01
`define MFP_OFS_PIN_CFG1  8'h10
`define MFP_OFS_PIN_CFG2  8'h11
`define MFP_OFS_PIN_CFG3  8'h12
`define MFP_OFS_PIN_CFG4  8'h13
`define MFP_OFS_PRESET    8'h14
`define MFP_OFS_VID       8'h97
`define MFP_SETUP_BIT     5
`define MFP_VID_EN_BIT    7
`define MFP_RST_DEV_CFG   8'h00
`define MFP_RST_PRESET    8'h01
// presets packed as {cfg4, cfg3, cfg2, cfg1}
`define MFP_PRESET1       32'hac42ce7f
`define MFP_PRESET2       32'hac28cc7f
`define MFP_PRESET3       32'h5c12001e
`define MFP_PRESET4       32'hac42ce7f
`define MFP_PRESET5       32'hac42ce7f
`define MFP_SMB_ADDR      7'h2c
`define MFP_NUM_PINS      15
`define MFP_HOT_W         16
// digital multifunction pin slots
`define MFP_PIN_1         0
`define MFP_PIN_2         1
`define MFP_PIN_3         2
`define MFP_PIN_4         3
`define MFP_PIN_7         4
`define MFP_PIN_8         5
`define MFP_PIN_13        6
`define MFP_PIN_21        7
`define MFP_PIN_22        8
`define MFP_PIN_27        9
`define MFP_PIN_28        10
`define MFP_PIN_29        11
`define MFP_PIN_30        12
`define MFP_PIN_31        13
`define MFP_PIN_32        14
`endif

// file: rtl/mfp_pkg.sv
// shared types for the pin setup block
`include "mfp_map.svh"
package mfp_pkg;
  typedef enum logic [3:0] {
    SB_IDLE, SB_ADDR, SB_ADDR_ACK, SB_CMD, SB_CMD_ACK,
    SB_WDATA, SB_WDATA_ACK, SB_RDATA, SB_RDATA_ACK
  } mfp_sb_state_t;
  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } mfp_reg_wr_t;
  typedef struct packed {
    logic [7:0] four;
    logic [7:0] three;
    logic [7:0] two;
    logic [7:0] one;
  } mfp_pin_cfg_t;
  typedef struct packed {
    logic          sclMeta, sclSync, sclPrev;
    logic          sdaMeta, sdaSync, sdaPrev;
    mfp_sb_state_t st;
    logic [3:0]    bitCnt;
    logic [7:0]    shifter;
    logic          rw, nack, sdaDrive;
    logic [7:0]    ptr;
    mfp_reg_wr_t   wr;
  } mfp_sb_t;
  typedef struct packed {
    logic [15:0] pre;
    logic [7:0]  phase;
    logic        pullLow;
  } mfp_fan_t;
  typedef struct packed {
    logic [7:0]                          devCfg;
    logic [7:0]                          preset;
    mfp_pin_cfg_t                        cfg;
    logic [`MFP_NUM_PINS-1:0]            pinMeta;
    logic [`MFP_NUM_PINS-1:0]            pinSync;
    logic [`MFP_NUM_PINS-1:0]            pinOe;
    logic [7:0]                          vidValue;
    logic [1:0][`MFP_HOT_W-1:0]          hotTime;
    logic [1:0]                          cpuHot;
    logic [1:0][1:0]                     ownDrive;
    logic [7:0]                          speedSense;
    logic [3:0]                          gpioLevel;
    logic                                caseOpen;
  } mfp_core_t;
endpackage

// file: rtl/mfp_smbus_slave.sv
// two-wire register port: pointer write, data write, data read
`timescale 1ns/100ps
module mfp_smbus_slave #(
  parameter logic [6:0] DEV_ADDR = `MFP_SMB_ADDR
) (
  input  logic                 ref_clk, // system clock
  input  logic                 resetn,  // sync reset, low
  input  logic                 sclIn,   // clock pin level
  input  logic                 sdaIn,   // data pin level
  output logic                 sdaOut,  // data pin drive value
  output logic                 sdaOe,   // data pin pulled low
  output logic [7:0]           rdAddr,  // register being read
  input  logic [7:0]           rdData,  // value at rdAddr
  output mfp_pkg::mfp_reg_wr_t regWr    // one-cycle write strobe
);
  import mfp_pkg::*;
  mfp_sb_t s, next_s;
  logic sclRise, sclFall, startSeen, stopSeen;
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_chk
    $error("reserved bus address");
  end
  assign sclRise = s.sclSync & ~s.sclPrev;
  assign sclFall = ~s.sclSync & s.sclPrev;
  assign startSeen = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
  assign stopSeen = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
  assign sdaOut = 1'b0;
  assign sdaOe = s.sdaDrive;
  assign rdAddr = s.ptr;
  assign regWr = s.wr;
  always_comb begin
    next_s = s;
    next_s.sclMeta = sclIn;
    next_s.sclSync = s.sclMeta;
    next_s.sclPrev = s.sclSync;
    next_s.sdaMeta = sdaIn;
    next_s.sdaSync = s.sdaMeta;
    next_s.sdaPrev = s.sdaSync;
    next_s.wr.stb = 1'b0;
    if (stopSeen) begin
      next_s.st = SB_IDLE;
      next_s.sdaDrive = 1'b0;
    end else if (startSeen) begin
      next_s.st = SB_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.sdaDrive = 1'b0;
    end else if (sclRise) begin
      unique case (s.st)
        SB_ADDR, SB_CMD, SB_WDATA: begin
          next_s.shifter = {s.shifter[6:0], s.sdaSync};
          next_s.bitCnt = s.bitCnt + 4'h1;
        end
        SB_RDATA: next_s.bitCnt = s.bitCnt + 4'h1;
        SB_RDATA_ACK: next_s.nack = s.sdaSync;
        SB_IDLE, SB_ADDR_ACK, SB_CMD_ACK, SB_WDATA_ACK: ;
      endcase
    end else if (sclFall) begin
      unique case (s.st)
        SB_IDLE: ;
        SB_ADDR: if (s.bitCnt == 4'h8) begin
          next_s.st = SB_IDLE;
          if (s.shifter[7:1] == DEV_ADDR) begin
            next_s.rw = s.shifter[0];
            next_s.st = SB_ADDR_ACK;
            next_s.sdaDrive = 1'b1;
          end
        end
        SB_CMD: if (s.bitCnt == 4'h8) begin
          next_s.ptr = s.shifter;
          next_s.st = SB_CMD_ACK;
          next_s.sdaDrive = 1'b1;
        end
        SB_WDATA: if (s.bitCnt == 4'h8) begin
          next_s.wr = '{stb: 1'b1, addr: s.ptr, data: s.shifter};
          next_s.st = SB_WDATA_ACK;
          next_s.sdaDrive = 1'b1;
        end
        SB_CMD_ACK, SB_WDATA_ACK: begin
          next_s.sdaDrive = 1'b0;
          next_s.bitCnt = 4'h0;
          next_s.st = SB_WDATA;
          // pointer steps only after the write strobe used it
          if (s.st == SB_WDATA_ACK) next_s.ptr = s.ptr + 8'h01;
        end
        SB_RDATA: if (s.bitCnt == 4'h8) begin
          next_s.sdaDrive = 1'b0;
          next_s.st = SB_RDATA_ACK;
        end else begin
          next_s.sdaDrive = ~s.shifter[7];
          next_s.shifter = {s.shifter[6:0], 1'b0};
        end
        SB_ADDR_ACK, SB_RDATA_ACK: begin
          next_s.sdaDrive = 1'b0;
          next_s.bitCnt = 4'h0;
          next_s.st = SB_CMD;
          if ((s.st == SB_ADDR_ACK && s.rw) || (s.st == SB_RDATA_ACK && !s.nack)) begin
            next_s.st = SB_RDATA;
            next_s.sdaDrive = ~rdData[7];
            next_s.shifter = {rdData[6:0], 1'b0};
            next_s.ptr = s.ptr + 8'h01;
          end else if (s.st == SB_RDATA_ACK) begin
            next_s.st = SB_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) s <= '0;
    else s <= next_s;
  end
endmodule

// file: rtl/mfp_fan_drive.sv
// open-drain pulse-width fan drive, high share set by duty
`timescale 1ns/100ps
module mfp_fan_drive #(
  parameter int PRESCALE = 4
) (
  input  logic       ref_clk, // system clock
  input  logic       resetn,  // sync reset, low
  input  logic [7:0] duty,    // high time in 1/256 steps
  input  logic       enable,  // pin serves as fan drive
  output logic       driveOe  // pull pin low
);
  import mfp_pkg::*;
  mfp_fan_t s, next_s;
  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_chk
    $error("prescale out of range");
  end
  assign driveOe = s.pullLow;
  always_comb begin
    next_s = s;
    next_s.pre = s.pre + 16'h0001;
    if (s.pre == 16'(PRESCALE - 1)) begin
      next_s.pre = 16'h0000;
      next_s.phase = s.phase + 8'h01;
    end
    // released when disabled: the pull-up then runs the fan flat out
    next_s.pullLow = enable && (s.phase >= duty);
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) s <= '0;
    else s <= next_s;
  end
endmodule

// file: rtl/mfp_pin_setup.sv
// multifunction pin setup: presets, per-pin overrides, pin functions
// Notes on behaviour
// - preset register bit n loads preset n+1
// - pin registers override functions after preset
// - monitoring runs only after setup-complete
// - preset one applies from reset
// - voltage-code enable overrides shared fan pins
// - register 1 picks speed senses, diodes
// - register 2 picks sense six, drive four
// - register 3 picks analog inputs, case-open
// - register 4 picks overtemp pins, drives
// - fan drives are open-drain pulse-width
// - voltage-code pins readable in value register
// - overtemp pins time hot input, drive out
// - general pins are open-drain, read back
// - preset two shares voltage-code, fan pins; presets here leave the voltage-code enable as it was
`timescale 1ns/100ps
module mfp_pin_setup #(
  parameter logic [6:0] DEV_ADDR = `MFP_SMB_ADDR,
  parameter int         FAN_PRESCALE = 4
) (
  input  logic                             ref_clk,       // 20 MHz clock
  input  logic                             resetn,        // sync reset, low
  input  logic                             sclIn,         // bus clock pin
  input  logic                             sdaIn,         // bus data pin in
  output logic                             sdaOut,        // bus data drive value
  output logic                             sdaOe,         // bus data pulled low
  input  logic [`MFP_NUM_PINS-1:0]         mfPinIn,       // pin levels
  output logic [`MFP_NUM_PINS-1:0]         mfPinOut,      // pin drive values
  output logic [`MFP_NUM_PINS-1:0]         mfPinOe,       // pins pulled low
  input  logic [3:0][7:0]                  fanDuty,       // fan drive duties
  input  logic [1:0]                       overtempReq,   // assert overtemp pins
  input  logic                             fanFault,      // fan fault seen
  input  logic [3:0]                       gpioDrive,     // general pin levels
  input  logic [1:0]                       hotTimeClr,    // clear hot timers
  output logic                             monitorEnable, // channels monitored
  output mfp_pkg::mfp_pin_cfg_t            pinCfg,        // live pin selects
  output logic [7:0]                       speedSense,    // speed sense levels
  output logic [1:0]                       cpuHot,        // hot input asserted
  output logic [1:0][`MFP_HOT_W-1:0]       hotTime,       // hot cycles counted
  output logic [3:0]                       gpioLevel,     // general pin readback
  output logic                             caseOpen,      // case-open level
  output logic [7:0]                       vidValue       // voltage-code value
);
  import mfp_pkg::*;

  localparam mfp_core_t RST = '{
    devCfg: `MFP_RST_DEV_CFG,
    preset: `MFP_RST_PRESET,
    cfg: `MFP_PRESET1,
    default: '0
  };
  localparam int TACH_PIN [8] = '{
    `MFP_PIN_1, `MFP_PIN_2, `MFP_PIN_3, `MFP_PIN_4,
    `MFP_PIN_7, `MFP_PIN_8, `MFP_PIN_21, `MFP_PIN_22
  };
  localparam int FAN_PIN [4] = '{
    `MFP_PIN_31, `MFP_PIN_32, `MFP_PIN_30, `MFP_PIN_13
  };
  localparam int GPIO_PIN [4] = '{
    `MFP_PIN_31, `MFP_PIN_32, `MFP_PIN_28, `MFP_PIN_29
  };
  localparam int THERM_PIN [2] = '{`MFP_PIN_28, `MFP_PIN_29};

  mfp_core_t   s, next_s;
  mfp_reg_wr_t regWr;
  logic [7:0]  rdAddr;
  logic [7:0]  rdData;
  logic        vidEn;
  logic        running;
  logic [7:0]  tachEn;
  logic [3:0]  fanEn;
  logic [3:0]  fanOe;
  logic [3:0]  gpioEn;
  logic [1:0]  thermEn;
  logic        ciEn;
  logic [6:0]  vidPins;

  // lowest set bit wins when the host sets several at once
  function automatic mfp_pin_cfg_t presetLoad(
    input logic [7:0]   sel,
    input mfp_pin_cfg_t cur
  );
    mfp_pin_cfg_t t;
    t = cur;
    if (sel[0]) begin
      t = `MFP_PRESET1;
    end else if (sel[1]) begin
      t = `MFP_PRESET2;
    end else if (sel[2]) begin
      t = `MFP_PRESET3;
    end else if (sel[3]) begin
      t = `MFP_PRESET4;
    end else if (sel[4]) begin
      t = `MFP_PRESET5;
    end
    // voltage-code enable is not part of any preset
    t.one[`MFP_VID_EN_BIT] = cur.one[`MFP_VID_EN_BIT];
    return t;
  endfunction

  mfp_smbus_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_bus (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .regWr   (regWr)
  );

  genvar g;
  for (g = 0; g < 4; g++) begin : g_fan
    mfp_fan_drive #(
      .PRESCALE (FAN_PRESCALE)
    ) u_fan (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .duty    (fanDuty[g]),
      .enable  (fanEn[g] & running),
      .driveOe (fanOe[g])
    );
  end

  assign vidEn = s.cfg.one[`MFP_VID_EN_BIT];
  assign running = s.devCfg[`MFP_SETUP_BIT];

  // function decode from the live selects
  always_comb begin
    tachEn[0] = s.cfg.one[4] & ~vidEn;
    tachEn[1] = s.cfg.one[3] & ~vidEn;
    tachEn[2] = s.cfg.one[2] & ~vidEn;
    tachEn[3] = s.cfg.one[1] & ~vidEn;
    tachEn[4] = s.cfg.one[0];
    tachEn[5] = s.cfg.two[7];
    tachEn[6] = s.cfg.two[3];
    tachEn[7] = s.cfg.two[2];
    fanEn[0] = s.cfg.four[3] & ~vidEn;
    fanEn[1] = s.cfg.four[2] & ~vidEn;
    fanEn[2] = 1'b1;
    fanEn[3] = s.cfg.two[6];
    thermEn[0] = s.cfg.four[7] & ~vidEn;
    thermEn[1] = s.cfg.four[5];
    gpioEn[0] = ~s.cfg.four[3] & ~vidEn;
    gpioEn[1] = ~s.cfg.four[2] & ~vidEn;
    gpioEn[2] = (s.cfg.four[7:6] == 2'b01) & ~vidEn;
    gpioEn[3] = (s.cfg.four[5:4] == 2'b01);
    ciEn = s.cfg.three[1];
    vidPins = {
      s.pinSync[`MFP_PIN_28], s.pinSync[`MFP_PIN_32],
      s.pinSync[`MFP_PIN_31], s.pinSync[`MFP_PIN_4],
      s.pinSync[`MFP_PIN_3], s.pinSync[`MFP_PIN_2],
      s.pinSync[`MFP_PIN_1]
    };
  end

  always_comb begin
    unique case (rdAddr)
      `MFP_OFS_DEV_CFG: rdData = s.devCfg;
      `MFP_OFS_PIN_CFG1: rdData = s.cfg.one;
      `MFP_OFS_PIN_CFG2: rdData = s.cfg.two;
      `MFP_OFS_PIN_CFG3: rdData = s.cfg.three;
      `MFP_OFS_PIN_CFG4: rdData = s.cfg.four;
      `MFP_OFS_PRESET: rdData = s.preset;
      `MFP_OFS_VID: rdData = s.vidValue;
      default: rdData = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.pinMeta = mfPinIn;
    next_s.pinSync = s.pinMeta;
    if (regWr.stb) begin
      unique case (regWr.addr)
        `MFP_OFS_DEV_CFG: next_s.devCfg = regWr.data;
        `MFP_OFS_PIN_CFG1: next_s.cfg.one = regWr.data;
        `MFP_OFS_PIN_CFG2: next_s.cfg.two = regWr.data;
        `MFP_OFS_PIN_CFG3: next_s.cfg.three = regWr.data;
        `MFP_OFS_PIN_CFG4: next_s.cfg.four = regWr.data;
        `MFP_OFS_PRESET: begin
          next_s.preset = regWr.data;
          next_s.cfg = presetLoad(regWr.data, s.cfg);
        end
        default: ;
      endcase
    end

    // pin drive: open-drain everywhere, so only the enables move
    next_s.pinOe = '0;
    for (int i = 0; i < 4; i++) begin
      if (fanEn[i] && fanOe[i]) next_s.pinOe[FAN_PIN[i]] = 1'b1;
      if (gpioEn[i] && !gpioDrive[i]) next_s.pinOe[GPIO_PIN[i]] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (thermEn[i] && running && overtempReq[i]) begin
        next_s.pinOe[THERM_PIN[i]] = 1'b1;
      end
    end
    // full-speed-on-fault output when case-open is not selected
    if (!ciEn && running && fanFault) next_s.pinOe[`MFP_PIN_27] = 1'b1;

    // sensing side, held quiet until setup completes except the general pin readback
    for (int i = 0; i < 8; i++) begin
      next_s.speedSense[i] = running & tachEn[i] & s.pinSync[TACH_PIN[i]];
    end
    for (int i = 0; i < 4; i++) begin
      next_s.gpioLevel[i] = gpioEn[i] & s.pinSync[GPIO_PIN[i]];
    end
    next_s.caseOpen = running & ciEn & s.pinSync[`MFP_PIN_27];
    for (int i = 0; i < 2; i++) begin
      // own drive reads back low for two more cycles through the synchroniser
      next_s.ownDrive[i] = {s.ownDrive[i][0], s.pinOe[THERM_PIN[i]]};
      next_s.cpuHot[i] = running & thermEn[i] & ~s.pinSync[THERM_PIN[i]] &
                         ~s.pinOe[THERM_PIN[i]] & ~|s.ownDrive[i];
      if (hotTimeClr[i]) begin
        next_s.hotTime[i] = {{(`MFP_HOT_W-1){1'b0}}, s.cpuHot[i]};
      end else if (s.cpuHot[i] && s.hotTime[i] != {`MFP_HOT_W{1'b1}}) begin
        next_s.hotTime[i] = s.hotTime[i] + {{(`MFP_HOT_W-1){1'b0}}, 1'b1};
      end
    end
    if (!vidEn) begin
      next_s.vidValue = 8'h00;
    end else if (running) begin
      next_s.vidValue = {1'b0, vidPins};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) s <= RST;
    else s <= next_s;
  end

  assign mfPinOut = '0;
  assign mfPinOe = s.pinOe;
  assign monitorEnable = running;
  assign pinCfg = s.cfg;
  assign speedSense = s.speedSense;
  assign cpuHot = s.cpuHot;
  assign hotTime = s.hotTime;
  assign gpioLevel = s.gpioLevel;
  assign caseOpen = s.caseOpen;
  assign vidValue = s.vidValue;
endmodule

// file: tb/mfp_pin_setup_chk.sv
// port assertions for the multifunction pin setup block
`timescale 1ns/100ps
`include "mfp_map.svh"
module mfp_pin_setup_chk (
  input logic                       ref_clk,       // clock
  input logic                       resetn,        // sync reset, low
  input logic                       sdaOut,        // bus data drive value
  input logic [`MFP_NUM_PINS-1:0]   mfPinOut,      // pin drive values
  input logic [`MFP_NUM_PINS-1:0]   mfPinOe,       // pins pulled low
  input logic [1:0]                 overtempReq,   // overtemp request
  input logic [3:0]                 gpioDrive,     // general pin levels
  input logic [1:0]                 hotTimeClr,    // hot timer clear
  input logic                       monitorEnable, // channels monitored
  input mfp_pkg::mfp_pin_cfg_t      pinCfg,        // live pin selects
  input logic [7:0]                 speedSense,    // speed sense levels
  input logic [1:0]                 cpuHot,        // hot input seen
  input logic [1:0][`MFP_HOT_W-1:0] hotTime,       // hot cycle counts
  input logic                       caseOpen,      // case-open level
  input logic [7:0]                 vidValue       // voltage-code value
);
  import mfp_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rst_cfg;
    $rose(resetn) |-> pinCfg == `MFP_PRESET1 && !monitorEnable && mfPinOe == '0;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("selects wrong after reset");
  property p_no_mon;
    !monitorEnable |-> speedSense == 8'h00 && cpuHot == 2'b00 && !caseOpen;
  endproperty
  a_no_mon: assert property (p_no_mon) else $error("monitoring before setup");
  property p_fan_idle;
    (!monitorEnable) [*3] |-> !mfPinOe[`MFP_PIN_30];
  endproperty
  a_fan_idle: assert property (p_fan_idle) else $error("fan drive before setup");
  property p_open_drain;
    mfPinOut == '0 && !sdaOut && !vidValue[7];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_vid_off;
    (!pinCfg.one[7]) [*2] |-> vidValue == 8'h00;
  endproperty
  a_vid_off: assert property (p_vid_off) else $error("code value while off");
  property p_vid_mute;
    pinCfg.one[7] [*5] |-> speedSense[3:0] == 4'h0 && mfPinOe[3:0] == 4'h0
      && mfPinOe[14:13] == 2'b00 && !mfPinOe[`MFP_PIN_28];
  endproperty
  a_vid_mute: assert property (p_vid_mute) else $error("shared pin not released");
  property p_ot_drive;
    (monitorEnable && overtempReq[0] && pinCfg.four[7] && !pinCfg.one[7]) [*2]
      |-> mfPinOe[`MFP_PIN_28];
  endproperty
  a_ot_drive: assert property (p_ot_drive) else $error("overtemp not driven");
  property p_gpio_drive;
    (monitorEnable && pinCfg.four[7:6] == 2'b01 && !pinCfg.one[7] && !gpioDrive[2]) [*2]
      |-> mfPinOe[`MFP_PIN_28];
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("general pin not low");
  property p_hot_clr;
    hotTimeClr[0] |=> hotTime[0] <= 16'd1;
  endproperty
  a_hot_clr: assert property (p_hot_clr) else $error("hot timer not cleared");
  property p_hot_hold;
    !cpuHot[0] && !hotTimeClr[0] ##1 !cpuHot[0] |-> $stable(hotTime[0]);
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("hot timer moved idle");
  c_setup: cover property ($rose(monitorEnable));
  c_hot: cover property (cpuHot[0]);
  c_vid: cover property (pinCfg.one[7] && monitorEnable);
endmodule

// file: tb/mfp_smb_host.sv
// two-wire bus host that writes and reads the block's registers
`timescale 1ns/100ps
`include "mfp_map.svh"
module mfp_smb_host #(
  parameter logic [6:0] DEV_ADDR = `MFP_SMB_ADDR
) (
  input  logic       ref_clk, // system clock
  input  logic       sda,     // resolved data line
  output logic       scl,     // bus clock, idle high
  output logic       sdaLow,  // pulls data line low
  output logic [7:0] rdByte,  // byte just read
  output logic       rdValid  // one cycle per byte read
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdByte = 8'h00;
    rdValid = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // half bit of 9 clocks stays above the synchroniser minimum
  task automatic bitIo(input logic b, output logic s);
    sdaLow = !b;
    hold(9);
    scl = 1'b1;
    hold(9);
    s = sda;
    scl = 1'b0;
    hold(2);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(1'b1, a);
  endtask
  task automatic start(input logic again);
    if (again) begin
      sdaLow = 1'b0;
      hold(9);
      scl = 1'b1;
    end
    hold(9);
    sdaLow = 1'b1;
    hold(9);
    scl = 1'b0;
    hold(2);
  endtask
  task automatic stop;
    sdaLow = 1'b1;
    hold(9);
    scl = 1'b1;
    hold(9);
    sdaLow = 1'b0;
    hold(9);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start(1'b0);
    xfer({DEV_ADDR, 1'b0}, q);
    xfer(a, q);
    xfer(d, q);
    stop;
  endtask
  // last byte ends in a release, which the slave takes as no-ack
  task automatic rd(input logic [7:0] a);
    logic [7:0] q;
    start(1'b0);
    xfer({DEV_ADDR, 1'b0}, q);
    xfer(a, q);
    start(1'b1);
    xfer({DEV_ADDR, 1'b1}, q);
    xfer(8'hff, q);
    rdByte = q;
    rdValid = 1'b1;
    hold(1);
    rdValid = 1'b0;
    stop;
  endtask
endmodule

// file: tb/mfp_pin_setup_tb.sv
// testbench for the multifunction pin setup block
`timescale 1ns/100ps
`include "mfp_map.svh"
module mfp_pin_setup_tb;
  import mfp_pkg::*;
  logic                           ref_clk = 1'b0;
  logic                           resetn = 1'b0;
  logic                           scl, sdaLow, sdaOut, sdaOe, rdValid, sdaLine;
  logic [7:0]                     rdByte, speedSense, vidValue;
  logic [`MFP_NUM_PINS-1:0]       extLevel, pinIn, mfPinOut, mfPinOe;
  logic [3:0][7:0]                fanDuty = {4{8'h80}};
  logic [1:0]                     overtempReq = 2'b00, hotTimeClr = 2'b00, cpuHot;
  logic                           fanFault = 1'b0, monitorEnable, caseOpen;
  logic [3:0]                     gpioDrive = 4'hf, gpioLevel;
  logic [1:0][`MFP_HOT_W-1:0]     hotTime;
  mfp_pin_cfg_t                   pinCfg;
  logic [7:0]                     expQ[$];
  logic [31:0] presets [5] = '{`MFP_PRESET1, `MFP_PRESET2, `MFP_PRESET3,
                               `MFP_PRESET4, `MFP_PRESET5};
  logic [7:0]  duties [3] = '{8'h00, 8'h40, 8'hff};
  int                             failures = 0, checkCount = 0;
  // open-drain lines: pull-up unless someone pulls low
  assign sdaLine = !(sdaLow || sdaOe);
  assign pinIn = extLevel & ~mfPinOe;
  always #25 ref_clk = ~ref_clk;
  mfp_smb_host mfp_smb_host_inst (.ref_clk, .sda(sdaLine), .scl, .sdaLow, .rdByte, .rdValid);
  mfp_pin_setup #(.FAN_PRESCALE(1)) mfp_pin_setup_inst (
    .ref_clk, .resetn, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe, .mfPinIn(pinIn),
    .mfPinOut, .mfPinOe, .fanDuty, .overtempReq, .fanFault, .gpioDrive, .hotTimeClr,
    .monitorEnable, .pinCfg, .speedSense, .cpuHot, .hotTime, .gpioLevel, .caseOpen, .vidValue);
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdExp(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    mfp_smb_host_inst.rd(a);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected read", 32'h0, 32'h1);
      else chk("read byte", {24'h0, expQ.pop_front()}, {24'h0, rdByte});
    end
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    failures++;
    test_done;
  end
  initial begin
    logic [7:0]  v;
    logic [31:0] cnt;
    extLevel = '1;
    repeat (16) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    tick(4);
    void'($urandom(32'h110e));
    chk("pin selects", presets[0], pinCfg);
    chk("speed senses", 0, speedSense);
    rdExp(8'h01, `MFP_RST_DEV_CFG);
    rdExp(8'h14, `MFP_RST_PRESET);
    for (int k = 0; k < 4; k++) rdExp(8'h10 + k[7:0], presets[0][8*k +: 8]);
    rdExp(8'h20, 8'h00);
    // highest preset first so preset one is live at the end
    for (int n = 4; n >= 0; n--) begin
      mfp_smb_host_inst.wr(8'h14, 8'h01 << n);
      chk("pin selects", presets[n], pinCfg);
      for (int k = 0; k < 4; k++) rdExp(8'h10 + k[7:0], presets[n][8*k +: 8]);
    end
    for (int k = 1; k < 4; k++) begin
      v = 8'($urandom);
      mfp_smb_host_inst.wr(8'h10 + k[7:0], v);
      rdExp(8'h10 + k[7:0], v);
    end
    rdExp(8'h14, 8'h01);
    mfp_smb_host_inst.wr(8'h97, 8'($urandom));
    rdExp(8'h97, 8'h00);
    mfp_smb_host_inst.wr(8'h14, 8'h01);
    mfp_smb_host_inst.wr(8'h01, 8'h20);
    tick(1);
    chk("monitor enable", 1, monitorEnable);
    rdExp(8'h01, 8'h20);
    extLevel = 15'($urandom) | 15'h7c00;
    tick(5);
    chk("speed senses", {extLevel[8:7], extLevel[5:0]}, speedSense);
    chk("case open", extLevel[9], caseOpen);
    extLevel = '1;
    overtempReq = 2'b01;
    tick(6);
    chk("overtemp drive", 1, mfPinOe[`MFP_PIN_28]);
    chk("self hot", 0, cpuHot[0]);
    overtempReq = 2'b00;
    tick(6);
    chk("hot count", 0, hotTime[0]);
    extLevel[`MFP_PIN_28] = 1'b0;
    tick(20);
    extLevel[`MFP_PIN_28] = 1'b1;
    tick(8);
    chk("hot count", 20, hotTime[0]);
    hotTimeClr = 2'b01;
    tick(1);
    hotTimeClr = 2'b00;
    tick(2);
    chk("hot count", 0, hotTime[0]);
    foreach (duties[i]) begin
      fanDuty[2] = duties[i];
      tick(520);
      cnt = 0;
      repeat (256) begin
        cnt += mfPinOe[`MFP_PIN_30];
        tick(1);
      end
      chk("fan low count", 32'd256 - duties[i], cnt);
    end
    mfp_smb_host_inst.wr(8'h13, 8'h6c);
    gpioDrive = 4'hb;
    tick(2);
    chk("general drive", 1, mfPinOe[`MFP_PIN_28]);
    gpioDrive = 4'hf;
    extLevel[`MFP_PIN_28] = 1'b0;
    tick(5);
    chk("general drive", 0, mfPinOe[`MFP_PIN_28]);
    chk("general read", 0, gpioLevel[2]);
    extLevel[`MFP_PIN_28] = 1'b1;
    tick(5);
    chk("general read", 1, gpioLevel[2]);
    mfp_smb_host_inst.wr(8'h12, 8'h40);
    fanFault = 1'b1;
    tick(2);
    chk("fault drive", 1, mfPinOe[`MFP_PIN_27]);
    chk("case open", 0, caseOpen);
    fanFault = 1'b0;
    mfp_smb_host_inst.wr(8'h10, 8'hff);
    extLevel = 15'($urandom);
    tick(6);
    chk("speed senses", 0, speedSense[3:0]);
    chk("shared drives", 0, mfPinOe[14:13]);
    rdExp(8'h97, {1'b0, extLevel[10], extLevel[14:13], extLevel[3:0]});
    tick(4);
    test_done;
  end
endmodule
bind mfp_pin_setup mfp_pin_setup_chk mfp_pin_setup_chk_inst (
  .ref_clk, .resetn, .sdaOut, .mfPinOut, .mfPinOe, .overtempReq, .gpioDrive, .hotTimeClr,
  .monitorEnable, .pinCfg, .speedSense, .cpuHot, .hotTime, .caseOpen, .vidValue);
